// file: rtl/cme_defs.svh
`ifndef CME_DEFS_SVH
`define CME_DEFS_SVH

// control byte codes
`define CME_CMD_RD_MAIN 8'h30
`define CME_CMD_UPD_MAIN 8'h38
`define CME_CMD_RD_PROT 8'h34
`define CME_CMD_WR_PROT 8'h3C
`define CME_CMD_RD_SEC 8'h31
`define CME_CMD_UPD_SEC 8'h39
`define CME_CMD_CMP 8'h33

// memory geometry
`define CME_MAIN_BYTES 256
`define CME_PROT_BITS 32
`define CME_PROT_LIMIT 8'h20
`define CME_SEC_BYTES 4
`define CME_CMD_BITS 24
`define CME_EC_RESET 8'h07

// processing lengths, in microseconds and in link clock pulses at the nominal link rate
`define CME_T_EW_US 5000
`define CME_T_ONE_US 2500
`define CME_PULSES_EW 12'd255
`define CME_PULSES_ONE 12'd124
`define CME_PULSES_ABORT 12'd2

// reader side timing
`define CME_MCLK_HZ 25000000
`define CME_LINK_HZ 50000
`define CME_HALF_CYC (`CME_MCLK_HZ / (2 * `CME_LINK_HZ))
`define CME_GUARD_PULSES 300
`define CME_FIFO_DEPTH 4
`define CME_FIFO_WIDTH 8

`endif

// file: rtl/cme_pkg.sv
package cme_pkg;
   typedef enum logic [1:0] {CME_C_IDLE, CME_C_OUT, CME_C_PROC} cme_card_st_e;
   typedef enum logic [2:0] {CME_R_IDLE, CME_R_CMD_LO, CME_R_CMD_HI, CME_R_RX_LO, CME_R_RX_HI,
                             CME_R_PR_LO, CME_R_PR_HI} cme_rdr_st_e;
   typedef enum logic [1:0] {CME_K_NONE, CME_K_READ, CME_K_PROC} cme_kind_e;
endpackage

// file: rtl/cme_link_if.sv
interface cme_link_if;
   logic lnk_clk;
   logic lnk_rst;
   logic rdr_io_o;
   logic rdr_io_oe_n;
   logic crd_io_o;
   logic crd_io_oe_n;
   logic io_line;

   // open-drain data line with pull-up: any enabled low driver wins
   assign io_line = (rdr_io_oe_n | rdr_io_o) & (crd_io_oe_n | crd_io_o);

   modport card (input lnk_clk, input lnk_rst, input io_line, output crd_io_o, output crd_io_oe_n);
   modport reader (output lnk_clk, output lnk_rst, output rdr_io_o, output rdr_io_oe_n, input io_line);
endinterface

// file: rtl/cme_fifo.sv
`include "cme_defs.svh"
module cme_fifo #(
   parameter int W = `CME_FIFO_WIDTH,
   parameter int D = `CME_FIFO_DEPTH
) (
   // system
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   logic [W-1:0] mem_ff [D];
   logic [AW-1:0] wp_ff;
   logic [AW-1:0] rp_ff;
   logic [CW-1:0] cnt_ff;
   logic push;
   logic pop;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign in_ready_o = (cnt_ff != CW'(D));
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rp_ff];

   // storage written only on accepted words, no reset needed
   always_ff @(posedge mclk_i) begin
      if (ce_i && push) begin
         mem_ff[wp_ff] <= in_data_i;
      end
   end

   // pointers wrap at depth so any depth works
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
      end else if (ce_i) begin
         if (push) begin
            wp_ff <= (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
         end
         if (pop) begin
            rp_ff <= (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule

// file: rtl/cme_card.sv
`include "cme_defs.svh"
// Summary of operation
// - base four commands, security variant adds three
// - security variant reads, updates, compares security memory
// - 30h streams main memory LSB first to 255
// - reader gives (256-N)*8+1 pulses for main read
// - main memory reads always allowed
// - 34h outgoing mode, address and data ignored
// - protection read shifts 32 bits over 32 pulses
// - line released after last bit, extra pulse returns card to idle
// - protection bits readable, mark locked main bytes
// - 38h processing mode programs addressed byte
// - erase plus write takes 255 pulses
// - write only takes 124 pulses
// - erase only takes 124 pulses
// - pulse counts assume 50 kHz link clock
// - skip erase or write when not needed
// - locked byte ends processing after pulse two
// - 3Ch sets protection bit only on match
// - security codes 31h, 39h, 33h decoded
module cme_card #(
   parameter bit SECURITY = 1'b1,
   parameter logic [7:0] REF_BYTE = 8'hA5 // arbitrary reset value of reference bytes
) (
   // system
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // link to the reader
   cme_link_if.card lnk,
   // status
   output logic [1:0] mode_o,
   output logic verified_o
);
   logic [2:0] clk_sy_ff;
   logic [1:0] rst_sy_ff;
   logic [1:0] io_sy_ff;
   logic rise, fall, io_s, lrst;
   cme_pkg::cme_card_st_e st_ff;
   cme_pkg::cme_card_st_e dec_st;
   logic [23:0] sh_ff;
   logic [4:0] bcnt_ff;
   logic [7:0] cmd_ff, addr_ff, val_ff, dec_val;
   logic [11:0] cnt_ff, tot_ff, dec_tot;
   logic do_ff, dec_do, oe_n_ff;
   logic [1:0] mode_ff;
   logic [7:0] mem_ff [`CME_MAIN_BYTES];
   logic [`CME_PROT_BITS-1:0] prot_ff;
   logic [7:0] sec_ff [`CME_SEC_BYTES];
   logic [3:1] match_ff;
   logic verified_ff;
   logic [23:0] nxt_word;
   logic [7:0] w_ctrl, w_addr, w_data, sec_new, rd_idx, sec_byte;
   logic wr_en, locked, out_bit, commit;

   // link inputs come from another party: two flops before any use
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         clk_sy_ff <= 3'h0;
         rst_sy_ff <= 2'h0;
         io_sy_ff <= 2'h3;
      end else if (ce_i) begin
         clk_sy_ff <= {clk_sy_ff[1:0], lnk.lnk_clk};
         rst_sy_ff <= {rst_sy_ff[0], lnk.lnk_rst};
         io_sy_ff <= {io_sy_ff[0], lnk.io_line};
      end
   end
   assign rise = clk_sy_ff[1] & ~clk_sy_ff[2];
   assign fall = ~clk_sy_ff[1] & clk_sy_ff[2];
   assign io_s = io_sy_ff[1];
   assign lrst = rst_sy_ff[1];
   assign wr_en = !SECURITY || verified_ff;
   assign commit = (st_ff == cme_pkg::CME_C_PROC) && fall && (cnt_ff == tot_ff - 12'h001) && do_ff;
   // erase only on a 0->1 need, write only on a 1->0 need
   function automatic logic [11:0] upd_pulses(input logic [7:0] old_b, input logic [7:0] new_b);
      logic er;
      logic wr;
      er = |(~old_b & new_b);
      wr = |(old_b & ~new_b);
      if (er && wr) begin
         upd_pulses = `CME_PULSES_EW;
      end else if (er || wr) begin
         upd_pulses = `CME_PULSES_ONE;
      end else begin
         upd_pulses = `CME_PULSES_ABORT;
      end
   endfunction
   // command decode on the 24th sampled bit, control byte first
   always_comb begin
      nxt_word = {io_s, sh_ff[23:1]};
      w_ctrl = nxt_word[7:0];
      w_addr = nxt_word[15:8];
      w_data = nxt_word[23:16];
      locked = (w_addr < `CME_PROT_LIMIT) && prot_ff[w_addr[4:0]];
      sec_new = wr_en ? w_data : (sec_ff[w_addr[1:0]] & w_data);
      dec_st = cme_pkg::CME_C_IDLE;
      dec_tot = 12'h000;
      dec_do = 1'b0;
      dec_val = w_data;
      case (w_ctrl)
         `CME_CMD_RD_MAIN: begin
            dec_st = cme_pkg::CME_C_OUT;
            dec_tot = {9'h100 - {1'b0, w_addr}, 3'h0};
         end
         `CME_CMD_RD_PROT: begin
            dec_st = cme_pkg::CME_C_OUT;
            dec_tot = 12'(`CME_PROT_BITS);
         end
         `CME_CMD_UPD_MAIN: begin
            dec_st = cme_pkg::CME_C_PROC;
            dec_do = !locked && wr_en;
            dec_tot = dec_do ? upd_pulses(mem_ff[w_addr], w_data) : `CME_PULSES_ABORT;
         end
         `CME_CMD_WR_PROT: begin
            dec_st = cme_pkg::CME_C_PROC;
            dec_do = (w_addr < `CME_PROT_LIMIT) && wr_en && !locked && (w_data == mem_ff[w_addr]);
            dec_tot = dec_do ? `CME_PULSES_ONE : `CME_PULSES_ABORT;
         end
         `CME_CMD_RD_SEC: begin
            if (SECURITY) begin
               dec_st = cme_pkg::CME_C_OUT;
               dec_tot = 12'(`CME_SEC_BYTES * 8);
            end
         end
         `CME_CMD_UPD_SEC: begin
            if (SECURITY) begin
               dec_st = cme_pkg::CME_C_PROC;
               dec_do = (w_addr < 8'h04) && (wr_en || w_addr == 8'h00);
               dec_val = sec_new;
               dec_tot = dec_do ? upd_pulses(sec_ff[w_addr[1:0]], sec_new) : `CME_PULSES_ABORT;
            end
         end
         `CME_CMD_CMP: begin
            if (SECURITY) begin
               dec_st = cme_pkg::CME_C_PROC;
               dec_do = (w_addr != 8'h00) && (w_addr < 8'h04);
               dec_tot = `CME_PULSES_ABORT;
            end
         end
         default: begin
            dec_st = cme_pkg::CME_C_IDLE;
         end
      endcase
   end
   // outgoing bit, LSB first; reference bytes read low until verified
   always_comb begin
      rd_idx = addr_ff + cnt_ff[10:3];
      sec_byte = sec_ff[cnt_ff[4:3]];
      if (cmd_ff == `CME_CMD_RD_MAIN) begin
         out_bit = mem_ff[rd_idx][cnt_ff[2:0]];
      end else if (cmd_ff == `CME_CMD_RD_PROT) begin
         out_bit = prot_ff[cnt_ff[4:0]];
      end else begin
         out_bit = (cnt_ff[4:3] != 2'h0 && !verified_ff) ? 1'b0 : sec_byte[cnt_ff[2:0]];
      end
   end
   // protocol sequencer; reset line aborts whatever runs
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_ff <= cme_pkg::CME_C_IDLE;
         sh_ff <= 24'h000000;
         bcnt_ff <= 5'h00;
         cmd_ff <= 8'h00;
         addr_ff <= 8'h00;
         cnt_ff <= 12'h000;
         tot_ff <= 12'h000;
         do_ff <= 1'b0;
         val_ff <= 8'h00;
         oe_n_ff <= 1'b1;
      end else if (ce_i) begin
         if (lrst) begin
            st_ff <= cme_pkg::CME_C_IDLE;
            bcnt_ff <= 5'h00;
            oe_n_ff <= 1'b1;
         end else begin
            unique case (st_ff)
               cme_pkg::CME_C_IDLE: begin
                  if (rise) begin
                     sh_ff <= nxt_word;
                     if (bcnt_ff == 5'(`CME_CMD_BITS - 1)) begin
                        bcnt_ff <= 5'h00;
                        cmd_ff <= w_ctrl;
                        addr_ff <= w_addr;
                        st_ff <= dec_st;
                        tot_ff <= dec_tot;
                        do_ff <= dec_do;
                        val_ff <= dec_val;
                        cnt_ff <= 12'h000;
                     end else begin
                        bcnt_ff <= bcnt_ff + 5'h01;
                     end
                  end
               end
               cme_pkg::CME_C_OUT: begin
                  // the reader closes with one more pulse, which must not count as a command bit
                  if (fall) begin
                     cnt_ff <= cnt_ff + 12'h001;
                     if (cnt_ff == tot_ff) begin
                        oe_n_ff <= 1'b1;
                     end else if (cnt_ff == tot_ff + 12'h001) begin
                        st_ff <= cme_pkg::CME_C_IDLE;
                     end else begin
                        oe_n_ff <= out_bit; // a one is sent by letting go
                     end
                  end
               end
               cme_pkg::CME_C_PROC: begin
                  if (fall) begin
                     cnt_ff <= cnt_ff + 12'h001;
                     if (cnt_ff == tot_ff - 12'h001) begin
                        oe_n_ff <= 1'b1;
                        st_ff <= cme_pkg::CME_C_IDLE;
                     end else begin
                        oe_n_ff <= 1'b0;
                     end
                  end
               end
            endcase
         end
      end
   end
   // memories change only when processing completes, so an abort leaves them intact
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < `CME_MAIN_BYTES; i++) begin
            mem_ff[i] <= 8'hFF;
         end
         prot_ff <= '0;
         sec_ff[0] <= `CME_EC_RESET;
         for (int i = 1; i < `CME_SEC_BYTES; i++) begin
            sec_ff[i] <= REF_BYTE;
         end
         match_ff <= 3'h0;
         verified_ff <= 1'b0;
      end else if (ce_i && commit) begin
         case (cmd_ff)
            `CME_CMD_UPD_MAIN: mem_ff[addr_ff] <= val_ff;
            `CME_CMD_WR_PROT: prot_ff[addr_ff[4:0]] <= 1'b1;
            `CME_CMD_UPD_SEC: sec_ff[addr_ff[1:0]] <= val_ff;
            `CME_CMD_CMP: begin
               match_ff[addr_ff[1:0]] <= (val_ff == sec_ff[addr_ff[1:0]]);
               if (addr_ff[1:0] == 2'h3 && match_ff[1] && match_ff[2] && val_ff == sec_ff[3] &&
                   sec_ff[0][2:0] != 3'h0) begin
                  verified_ff <= 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end
   // status flops for the user side
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mode_ff <= 2'h0;
      end else if (ce_i) begin
         mode_ff <= (st_ff == cme_pkg::CME_C_OUT) ? 2'h1 : (st_ff == cme_pkg::CME_C_PROC) ? 2'h2 : 2'h0;
      end
   end
   assign lnk.crd_io_o = 1'b0;
   assign lnk.crd_io_oe_n = oe_n_ff;
   assign mode_o = mode_ff;
   assign verified_o = verified_ff;
endmodule

// file: rtl/cme_reader.sv
`include "cme_defs.svh"
module cme_reader #(
   parameter int HALF = `CME_HALF_CYC,
   parameter int GUARD = `CME_GUARD_PULSES,
   parameter int FIFO_DEPTH = `CME_FIFO_DEPTH
) (
   // system
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // link to the card
   cme_link_if.reader lnk,
   // command request
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [7:0] cmd_ctrl_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic [7:0] cmd_data_i,
   // received bytes
   output logic rx_valid_o,
   input wire logic rx_ready_i,
   output logic [7:0] rx_data_o,
   // status
   output logic done_o,
   output logic timeout_o
);
   cme_pkg::cme_rdr_st_e st_ff;
   cme_pkg::cme_kind_e kind_ff;
   cme_pkg::cme_kind_e nxt_kind;
   logic [11:0] nxt_rem;
   logic [15:0] tmr_ff;
   logic [1:0] io_sy_ff;
   logic [23:0] sh_ff;
   logic [4:0] bcnt_ff;
   logic [11:0] rem_ff;
   logic [7:0] byte_ff;
   logic [2:0] bpos_ff;
   logic last_ff;
   logic [8:0] guard_ff;
   logic clk_ff;
   logic oe_n_ff;
   logic rst_ff;
   logic ready_ff;
   logic done_ff;
   logic tout_ff;
   logic io_s;
   logic tend;
   logic push;
   logic fifo_ready;
   logic stall;

   // data line comes back from the card: two flops before use
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         io_sy_ff <= 2'h3;
      end else if (ce_i) begin
         io_sy_ff <= {io_sy_ff[0], lnk.io_line};
      end
   end

   assign io_s = io_sy_ff[1];
   assign tend = (tmr_ff == 16'(HALF - 1));
   assign push = (st_ff == cme_pkg::CME_R_RX_LO) && tend && (rem_ff != 12'h000) && (bpos_ff == 3'h7);
   assign stall = push && !fifo_ready; // hold the link clock low until the buffer drains

   // expected answer length per control byte
   always_comb begin
      nxt_kind = cme_pkg::CME_K_NONE;
      nxt_rem = 12'h000;
      case (cmd_ctrl_i)
         `CME_CMD_RD_MAIN: begin
            nxt_kind = cme_pkg::CME_K_READ;
            nxt_rem = {9'h100 - {1'b0, cmd_addr_i}, 3'h0};
         end
         `CME_CMD_RD_PROT, `CME_CMD_RD_SEC: begin
            nxt_kind = cme_pkg::CME_K_READ;
            nxt_rem = 12'(`CME_PROT_BITS);
         end
         `CME_CMD_UPD_MAIN, `CME_CMD_WR_PROT, `CME_CMD_UPD_SEC, `CME_CMD_CMP: begin
            nxt_kind = cme_pkg::CME_K_PROC;
         end
         default: begin
            nxt_kind = cme_pkg::CME_K_NONE;
         end
      endcase
   end

   // half-period timer paces every link phase
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tmr_ff <= 16'h0000;
      end else if (ce_i) begin
         if (st_ff == cme_pkg::CME_R_IDLE || (tend && !stall)) begin
            tmr_ff <= 16'h0000;
         end else if (!tend) begin
            tmr_ff <= tmr_ff + 16'h0001;
         end
      end
   end

   // link sequencer; data is set while the clock is low, read before each rise
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_ff <= cme_pkg::CME_R_IDLE;
         kind_ff <= cme_pkg::CME_K_NONE;
         sh_ff <= 24'h000000;
         bcnt_ff <= 5'h00;
         rem_ff <= 12'h000;
         byte_ff <= 8'h00;
         bpos_ff <= 3'h0;
         last_ff <= 1'b0;
         guard_ff <= 9'h000;
         clk_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         rst_ff <= 1'b1;
         ready_ff <= 1'b0;
         done_ff <= 1'b0;
         tout_ff <= 1'b0;
      end else if (ce_i) begin
         rst_ff <= 1'b0;
         done_ff <= 1'b0;
         unique case (st_ff)
            cme_pkg::CME_R_IDLE: begin
               ready_ff <= 1'b1;
               if (cmd_valid_i && ready_ff) begin
                  ready_ff <= 1'b0;
                  tout_ff <= 1'b0;
                  sh_ff <= {cmd_data_i, cmd_addr_i, cmd_ctrl_i};
                  oe_n_ff <= cmd_ctrl_i[0];
                  bcnt_ff <= 5'h00;
                  kind_ff <= nxt_kind;
                  rem_ff <= nxt_rem;
                  bpos_ff <= 3'h0;
                  last_ff <= 1'b0;
                  guard_ff <= 9'(GUARD);
                  st_ff <= cme_pkg::CME_R_CMD_LO;
               end
            end
            cme_pkg::CME_R_CMD_LO: begin
               if (tend) begin
                  clk_ff <= 1'b1;
                  st_ff <= cme_pkg::CME_R_CMD_HI;
               end
            end
            cme_pkg::CME_R_CMD_HI: begin
               if (tend) begin
                  clk_ff <= 1'b0;
                  if (bcnt_ff == 5'(`CME_CMD_BITS - 1)) begin
                     oe_n_ff <= 1'b1;
                     if (kind_ff == cme_pkg::CME_K_READ) begin
                        st_ff <= cme_pkg::CME_R_RX_LO;
                     end else if (kind_ff == cme_pkg::CME_K_PROC) begin
                        st_ff <= cme_pkg::CME_R_PR_LO;
                     end else begin
                        st_ff <= cme_pkg::CME_R_IDLE;
                        done_ff <= 1'b1;
                     end
                  end else begin
                     bcnt_ff <= bcnt_ff + 5'h01;
                     sh_ff <= {1'b0, sh_ff[23:1]};
                     oe_n_ff <= sh_ff[1];
                     st_ff <= cme_pkg::CME_R_CMD_LO;
                  end
               end
            end
            cme_pkg::CME_R_RX_LO: begin
               if (tend && !stall) begin
                  clk_ff <= 1'b1;
                  st_ff <= cme_pkg::CME_R_RX_HI;
                  if (rem_ff == 12'h000) begin
                     last_ff <= 1'b1;
                  end else begin
                     byte_ff <= {io_s, byte_ff[7:1]};
                     bpos_ff <= bpos_ff + 3'h1;
                     rem_ff <= rem_ff - 12'h001;
                  end
               end
            end
            cme_pkg::CME_R_RX_HI: begin
               if (tend) begin
                  clk_ff <= 1'b0;
                  if (last_ff) begin
                     st_ff <= cme_pkg::CME_R_IDLE;
                     done_ff <= 1'b1;
                  end else begin
                     st_ff <= cme_pkg::CME_R_RX_LO;
                  end
               end
            end
            cme_pkg::CME_R_PR_LO: begin
               if (tend) begin
                  if (io_s) begin
                     st_ff <= cme_pkg::CME_R_IDLE;
                     done_ff <= 1'b1;
                  end else if (guard_ff == 9'h000) begin
                     st_ff <= cme_pkg::CME_R_IDLE; // card never released the line
                     done_ff <= 1'b1;
                     tout_ff <= 1'b1;
                  end else begin
                     clk_ff <= 1'b1;
                     st_ff <= cme_pkg::CME_R_PR_HI;
                  end
               end
            end
            cme_pkg::CME_R_PR_HI: begin
               if (tend) begin
                  clk_ff <= 1'b0;
                  guard_ff <= guard_ff - 9'h001;
                  st_ff <= cme_pkg::CME_R_PR_LO;
               end
            end
         endcase
      end
   end

   // received bytes wait here for the user
   cme_fifo #(
      .W(8),
      .D(FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i({io_s, byte_ff[7:1]}),
      .out_valid_o(rx_valid_o),
      .out_ready_i(rx_ready_i),
      .out_data_o(rx_data_o)
   );

   assign lnk.lnk_clk = clk_ff;
   assign lnk.lnk_rst = rst_ff;
   assign lnk.rdr_io_o = 1'b0;
   assign lnk.rdr_io_oe_n = oe_n_ff;
   assign cmd_ready_o = ready_ff;
   assign done_o = done_ff;
   assign timeout_o = tout_ff;
endmodule

// file: tb/cme_link_sva.sv
module cme_link_sva (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // link wires
   input wire logic lnk_clk,
   input wire logic lnk_rst,
   input wire logic rdr_io_o,
   input wire logic rdr_io_oe_n,
   input wire logic crd_io_o,
   input wire logic crd_io_oe_n,
   input wire logic io_line
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic [8:0] low_ff;
   // link pulses while the card pulls low; reads rarely hold it this long
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || crd_io_oe_n) begin
         low_ff <= 9'h000;
      end else if ($rose(lnk_clk)) begin
         low_ff <= low_ff + 9'h001;
      end
   end
   a_card_open_drain: assert property (crd_io_o == 1'b0)
      else $error("card line driven high");
   a_wired_low: assert property (!crd_io_oe_n |-> !io_line)
      else $error("line not low");
   a_idle_after_rst: assert property ($rose(rst_n_i) |-> crd_io_oe_n [*4])
      else $error("card drives after reset");
   a_high_stable: assert property (lnk_clk && $past(lnk_clk) |-> $stable(io_line))
      else $error("line moved in high phase");
   a_pulse_high: assert property ($rose(lnk_clk) |-> lnk_clk [*8] ##1 !lnk_clk)
      else $error("high phase length");
   a_pulse_low: assert property ($fell(lnk_clk) |-> !lnk_clk [*8])
      else $error("low phase too short");
   a_no_clash: assert property (!rdr_io_oe_n |-> crd_io_oe_n)
      else $error("both ends drive");
   a_proc_bound: assert property (low_ff <= 9'd255)
      else $error("line held low too long");
endmodule

// file: tb/card_memory_command_executor_tb_top.sv
module card_memory_command_executor_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cv = 1'b0, rx_ready = 1'b0, rx_en = 1'b1, rdy, c_rdy, rx_valid, done, verified, tout;
   logic [7:0] cc = 8'h00, ca = 8'h00, cd = 8'h00, rx_data, o, n;
   logic [1:0] mode;
   logic [7:0] mem [256];
   logic [7:0] rxq [$];
   logic [7:0] exq [$];
   logic [31:0] prot = 32'h0;
   logic [31:0] seed = 32'hE1EFE6A7;
   int n_fail = 0, samples_checked = 0, cyc = 0, lows = 0, p;
   cme_link_if u_cme_link_if ();
   cme_card u_cme_card (.mclk_i, .rst_n_i, .ce_i(1'b1), .lnk(u_cme_link_if), .mode_o(mode), .verified_o(verified));
   cme_reader #(.HALF(8)) u_cme_reader (.mclk_i, .rst_n_i, .ce_i(1'b1), .lnk(u_cme_link_if), .cmd_valid_i(cv),
      .cmd_ready_o(c_rdy), .cmd_ctrl_i(cc), .cmd_addr_i(ca), .cmd_data_i(cd), .rx_valid_o(rx_valid),
      .rx_ready_i(rx_ready), .rx_data_o(rx_data), .done_o(done), .timeout_o(tout));
   cme_link_sva u_cme_link_sva (.mclk_i, .rst_n_i, .lnk_clk(u_cme_link_if.lnk_clk),
      .lnk_rst(u_cme_link_if.lnk_rst), .rdr_io_o(u_cme_link_if.rdr_io_o), .rdr_io_oe_n(u_cme_link_if.rdr_io_oe_n),
      .crd_io_o(u_cme_link_if.crd_io_o), .crd_io_oe_n(u_cme_link_if.crd_io_oe_n), .io_line(u_cme_link_if.io_line));
   initial forever #20 mclk_i = ~mclk_i;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // pulses a byte update needs: both steps, one step, or none
   function automatic int exp_t(logic [7:0] a, logic [7:0] b);
      if (((~a & b) != 8'h00) && ((a & ~b) != 8'h00)) return 255;
      if (a != b) return 124;
      return 2;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(string w, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic chk_rx();
      chk("rx count", exq.size(), rxq.size());
      foreach (exq[i]) chk("rx byte", exq[i], rxq[i]);
   endtask
   // request held until taken, then wait for completion and an empty buffer
   task automatic cmd(logic [7:0] c, logic [7:0] a, logic [7:0] d);
      @(negedge mclk_i);
      cc = c;
      ca = a;
      cd = d;
      cv = 1'b1;
      lows = 0;
      rxq.delete();
      while (c_rdy !== 1'b1) @(negedge mclk_i);
      @(negedge mclk_i);
      cv = 1'b0;
      while (done !== 1'b1) @(negedge mclk_i);
      while (rx_valid === 1'b1) @(negedge mclk_i);
      // card leaves a read on the closing pulse, seen a few cycles after done
      repeat (4) @(negedge mclk_i);
      chk("mode", 0, mode);
      chk("timeout", 0, tout);
   endtask
   // sink with random stalls; a byte is taken when it is offered to a ready edge
   always @(negedge mclk_i) begin
      rdy = rx_en && (rnd() % 3 != 0);
      if (rdy && rx_valid === 1'b1) rxq.push_back(rx_data);
      rx_ready <= rdy;
   end
   // card pulls low across these link rises
   always @(posedge u_cme_link_if.lnk_clk) if (u_cme_link_if.crd_io_oe_n === 1'b0) lows++;
   // watchdog, far above the expected run
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc > 90000) begin
         n_fail++;
         finish_test();
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
      repeat (8) @(negedge mclk_i);
      rst_n_i = 1'b1;
      cmd(8'h3D, 8'h00, 8'h00);
      chk("unknown lows", 0, lows);
      cmd(8'h30, 8'hFF, 8'h00);
      exq = {8'hFF};
      chk_rx();
      cmd(8'h38, 8'h40, 8'h00);
      chk("blocked update", 1, lows);
      cmd(8'h39, 8'h00, 8'h06);
      chk("counter write", 123, lows);
      for (int i = 1; i < 4; i++) cmd(8'h33, i[7:0], 8'hA5);
      chk("verified", 1, verified);
      cmd(8'h31, 8'h00, 8'h00);
      exq = {8'h06, 8'hA5, 8'hA5, 8'hA5};
      chk_rx();
      // same byte three times in a row: write only, erase only, then random
      for (int k = 0; k < 6; k++) begin
         if (k % 3 == 0) p = 224 + rnd() % 32;
         o = mem[p];
         n = 8'(rnd());
         if (k % 3 == 0) n = o & n;
         if (k % 3 == 1) n = o | n;
         cmd(8'h38, p[7:0], n);
         chk("update pulses", exp_t(o, n) - 1, lows);
         mem[p] = n;
      end
      rx_en = 1'b0;
      fork
         cmd(8'h30, 8'hE0, 8'h00);
         begin
            repeat (3000) @(negedge mclk_i);
            chk("stalled clock", 0, u_cme_link_if.lnk_clk);
            chk("buffer full", 1, rx_valid);
            chk("out mode", 1, mode);
            rx_en = 1'b1;
         end
      join
      exq.delete();
      for (int i = 224; i < 256; i++) exq.push_back(mem[i]);
      chk_rx();
      p = rnd() % 32;
      cmd(8'h3C, p[7:0], mem[p] ^ 8'h01);
      chk("prot mismatch", 1, lows);
      cmd(8'h3C, p[7:0], mem[p]);
      chk("prot set", 123, lows);
      prot[p] = 1'b1;
      cmd(8'h38, p[7:0], 8'h00);
      chk("locked", 1, lows);
      cmd(8'h34, 8'h00, 8'h00);
      exq = {prot[7:0], prot[15:8], prot[23:16], prot[31:24]};
      chk_rx();
      finish_test();
   end
endmodule
